/* File: rtl/supply_monitor_pkg.sv */
// Package for the supply monitor: register address, field layout, reset value and timing.
// Assumes a 10 MHz core clock; every count below is derived from that rate.
// Functional notes
// - When enabled the monitor watches both supplies and flags a drop below one of four trip points.
// - The interrupt toward the core is raised only while the external supply-fail enable is set.
// - Unless software clears it, the fail flag stays set until the failing supply has been good for at least 250 ms.
// - Short glitches on either comparator output are filtered before they can set the flag.
// - Bit 7 of the control register is read-only and mirrors the digital supply comparator.
// - Bit 6 of the control register is read-only and mirrors the analog supply comparator.
// - On the 5 V variant a digital supply drop causes a reset, so it never raises a monitor event.
// - The flag sets while either comparator is low and clears when the recovery count expires.
// - Software may write the flag, but a clear is ignored while either comparator is low.
// - The digital trip select codes 00, 01, 10 and 11 mean 4.63, 3.08, 2.93 and 2.63 V.
// - The analog trip select uses the same code, with 00, 01 and 10 as 4.63, 3.08 and 2.93 V.
package supply_monitor_pkg;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Register address and field layout.
    localparam logic [7:0] CONTROL_ADDR      = 8'hDF;
    localparam logic [7:0] CONTROL_RESET     = 8'hDE;
    localparam int         DIGITAL_CMP_BIT   = 7;
    localparam int         ANALOG_CMP_BIT    = 6;
    localparam int         FAIL_FLAG_BIT     = 5;
    localparam int         DIGITAL_TRIP_HI   = 4;
    localparam int         DIGITAL_TRIP_LO   = 3;
    localparam int         ANALOG_TRIP_HI    = 2;
    localparam int         ANALOG_TRIP_LO    = 1;
    localparam int         WATCH_ENABLE_BIT  = 0;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Trip point codes, shared by both selects.
    typedef enum logic [1:0] {
        TRIP_4V63 = 2'h0,
        TRIP_3V08 = 2'h1,
        TRIP_2V93 = 2'h2,
        TRIP_2V63 = 2'h3
    } trip_code_t;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Timing.
    localparam int CLOCK_HZ          = 10_000_000;
    localparam int RECOVERY_TIME_MS  = 250;
    localparam int RECOVERY_CYCLES   = RECOVERY_TIME_MS * (CLOCK_HZ / 1000);
    localparam int GLITCH_TIME_US    = 50;
    localparam int GLITCH_CYCLES     = GLITCH_TIME_US * (CLOCK_HZ / 1_000_000);

    // Recovery state machine.
    typedef enum logic [1:0] {
        WATCH_GOOD    = 2'h0,
        WATCH_LOW     = 2'h1,
        WATCH_RECOVER = 2'h2
    } watch_state_t;

endpackage

/* File: rtl/compare_filter_if.sv */
// Carrier between the monitor core and one comparator filter.
// Assumes the filter and its user share the core clock.
`timescale 1ns/1ns
interface compare_filter_if;
    logic raw;
    logic level;
    logic clean;

    // The filter sees the raw pin and returns the synchronised and filtered levels.
    modport filter (input raw, output level, output clean);
    modport user   (output raw, input level, input clean);
endinterface

/* File: rtl/compare_glitch_filter.sv */
// Synchroniser and glitch filter for one supply comparator output.
// Assumes the comparator is asynchronous to the core clock and idles high at reset.
`timescale 1ns/1ns
module compare_glitch_filter
    import supply_monitor_pkg::*;
#(
    parameter int FILTER_CYCLES = supply_monitor_pkg::GLITCH_CYCLES
) (
    input  wire logic                  clock,
    input  wire logic                  rstn,
    compare_filter_if.filter           port
);
    import supply_monitor_pkg::*;

    logic        syncA;
    logic        syncB;
    logic        syncC;
    logic        clean;
    logic [15:0] count;
    logic        next_clean;
    logic [15:0] next_count;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // A new level is taken only when it has held steadily for the whole filter span.
    always_comb begin
        next_clean = clean;
        next_count = 16'h0000;
        if ((syncB == syncC) && (syncC != clean)) begin
            if (count == 16'(FILTER_CYCLES - 1)) begin
                next_clean = syncC;
            end else begin
                next_count = count + 16'h0001;
            end
        end
    end

    // The first stage feeds only the second, so metastability cannot leak into the counter.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            syncA <= 1'b1;
            syncB <= 1'b1;
            syncC <= 1'b1;
            clean <= 1'b1;
            count <= 16'h0000;
        end else begin
            syncA <= port.raw;
            syncB <= syncA;
            syncC <= syncB;
            clean <= next_clean;
            count <= next_count;
        end
    end

    assign port.level = syncC;
    assign port.clean = clean;
endmodule

/* File: rtl/supply_monitor.sv */
// Digital side of the supply monitor: control register, comparator filtering and fail flag.
// Assumes the core presents one special function register access per cycle on the
// address, write and read strobes, and that the comparators arrive as raw pins.
// The comparators and the trip voltages live in the analog section; only the two-bit
// selects and the watch enable go out to it, and the comparator pins are taken as asynchronous.
`timescale 1ns/1ns
module supply_monitor
    import supply_monitor_pkg::*;
#(
    parameter int       RECOVERY_COUNT = supply_monitor_pkg::RECOVERY_CYCLES,
    parameter int       FILTER_COUNT   = supply_monitor_pkg::GLITCH_CYCLES,
    // Set for the 5 V part, whose digital drop trips the power-on reset instead.
    parameter bit       FIVE_VOLT_PART = 1'b0
) (
    input  wire logic                        clock,
    input  wire logic                        rstn,
    input  wire logic [7:0]                  sfrAddr,
    input  wire logic [7:0]                  sfrWrData,
    input  wire logic                        sfrWrite,
    input  wire logic                        sfrRead,
    output logic      [7:0]                  sfrRdData,
    input  wire logic                        irqEnablePriorityTwo,
    input  wire logic                        digitalSupplyCompareRaw,
    input  wire logic                        analogSupplyCompareRaw,
    output supply_monitor_pkg::trip_code_t   digitalTripSelect,
    output supply_monitor_pkg::trip_code_t   analogTripSelect,
    output logic                             supplyWatchEnable,
    output logic                             supplyFailIrq
);
    import supply_monitor_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Field extraction, shared by the write path and the reset values so the two never drift.
    function automatic trip_code_t digital_trip_field(input logic [7:0] regWord);
        return trip_code_t'(regWord[DIGITAL_TRIP_HI:DIGITAL_TRIP_LO]);
    endfunction

    function automatic trip_code_t analog_trip_field(input logic [7:0] regWord);
        return trip_code_t'(regWord[ANALOG_TRIP_HI:ANALOG_TRIP_LO]);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Comparator filters.
    // Both filters share one span; a per-supply span would need a second parameter.
    compare_filter_if digitalLink ();
    compare_filter_if analogLink ();

    assign digitalLink.raw = digitalSupplyCompareRaw;
    assign analogLink.raw  = analogSupplyCompareRaw;

    compare_glitch_filter #(
        .FILTER_CYCLES (FILTER_COUNT)
    ) digitalFilter (
        .clock (clock),
        .rstn  (rstn),
        .port  (digitalLink.filter)
    );

    compare_glitch_filter #(
        .FILTER_CYCLES (FILTER_COUNT)
    ) analogFilter (
        .clock (clock),
        .rstn  (rstn),
        .port  (analogLink.filter)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Register state.
    logic         supplyFailIrqFlag;
    trip_code_t   digitalTrip;
    trip_code_t   analogTrip;
    logic         watchEnable;
    logic [7:0]   readData;
    logic         irqOut;
    logic         next_supplyFailIrqFlag;
    trip_code_t   next_digitalTrip;
    trip_code_t   next_analogTrip;
    logic         next_watchEnable;
    logic [7:0]   next_readData;
    logic         next_irqOut;

    // Recovery state.
    watch_state_t state;
    watch_state_t next_state;
    logic [31:0]  recoverCount;
    logic [31:0]  next_recoverCount;

    // Derived conditions.
    logic         controlHit;
    logic         digitalLow;
    logic         analogLow;
    logic         anyLow;
    logic         recoveryDone;
    logic [7:0]   statusWord;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // A drop on the 5 V part's digital supply resets the chip instead, so it is masked here.
    // The enable gates only the flag; the status bits keep mirroring the pins while disabled.
    assign controlHit   = (sfrAddr == CONTROL_ADDR);
    assign digitalLow   = !digitalLink.clean && !FIVE_VOLT_PART;
    assign analogLow    = !analogLink.clean;
    assign anyLow       = watchEnable && (digitalLow || analogLow);
    assign recoveryDone = (state == WATCH_RECOVER) &&
                          (recoverCount == 32'(RECOVERY_COUNT - 1));

    // Status bits mirror the synchronised comparators, ahead of the glitch filter.
    // Reading them costs three cycles of lag but shows a dip that the filter would hide.
    always_comb begin
        statusWord                   = 8'h00;
        statusWord[DIGITAL_CMP_BIT]  = digitalLink.level;
        statusWord[ANALOG_CMP_BIT]   = analogLink.level;
        statusWord[FAIL_FLAG_BIT]    = supplyFailIrqFlag;
        statusWord[DIGITAL_TRIP_HI:DIGITAL_TRIP_LO] = digitalTrip;
        statusWord[ANALOG_TRIP_HI:ANALOG_TRIP_LO]   = analogTrip;
        statusWord[WATCH_ENABLE_BIT] = watchEnable;
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Recovery sequencing: the count restarts from zero on any fresh drop.
    // Outside recovery the count is held at zero, so a fresh low needs no separate clear.
    // The 32-bit count covers the full recovery span at the core rate with room to spare.
    always_comb begin
        next_state        = state;
        next_recoverCount = 32'h0000_0000;
        case (state)
            WATCH_GOOD: begin
                if (anyLow) begin
                    next_state = WATCH_LOW;
                end
            end
            WATCH_LOW: begin
                if (!anyLow) begin
                    next_state = WATCH_RECOVER;
                end
            end
            WATCH_RECOVER: begin
                if (anyLow) begin
                    next_state = WATCH_LOW;
                end else if (recoveryDone) begin
                    next_state = WATCH_GOOD;
                end else begin
                    next_recoverCount = recoverCount + 32'h0000_0001;
                end
            end
            default: begin
                next_state = WATCH_GOOD;
            end
        endcase
    end

    // State and count registers.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state        <= WATCH_GOOD;
            recoverCount <= 32'h0000_0000;
        end else begin
            state        <= next_state;
            recoverCount <= next_recoverCount;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Register writes and the fail flag. Hardware setting wins over a software clear in the
    // same cycle, and a clear is refused outright while a supply is still low.
    // Bits 7 and 6 are never stored: writes to them are dropped and reads show the pins.
    always_comb begin
        next_digitalTrip       = digitalTrip;
        next_analogTrip        = analogTrip;
        next_watchEnable       = watchEnable;
        next_supplyFailIrqFlag = supplyFailIrqFlag;
        if (sfrWrite && controlHit) begin
            next_digitalTrip       = digital_trip_field(sfrWrData);
            next_analogTrip        = analog_trip_field(sfrWrData);
            next_watchEnable       = sfrWrData[WATCH_ENABLE_BIT];
            next_supplyFailIrqFlag = sfrWrData[FAIL_FLAG_BIT];
        end
        if (recoveryDone) begin
            next_supplyFailIrqFlag = 1'b0;
        end
        if (anyLow) begin
            next_supplyFailIrqFlag = 1'b1;
        end
    end

    // Reads are registered, so data appears one cycle after the strobe; other addresses read 0.
    // Registering keeps the read port straight from a flip-flop at the cost of that cycle.
    always_comb begin
        next_readData = 8'h00;
        if (sfrRead && controlHit) begin
            next_readData = statusWord;
        end
        // The enable is sampled here, so the interrupt line follows it one cycle late.
        next_irqOut = supplyFailIrqFlag && irqEnablePriorityTwo;
    end

    // Register bank; reset loads the power-on value of the control register field by field.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            digitalTrip       <= digital_trip_field(CONTROL_RESET);
            analogTrip        <= analog_trip_field(CONTROL_RESET);
            watchEnable       <= CONTROL_RESET[WATCH_ENABLE_BIT];
            supplyFailIrqFlag <= CONTROL_RESET[FAIL_FLAG_BIT];
            readData          <= 8'h00;
            irqOut            <= 1'b0;
        end else begin
            digitalTrip       <= next_digitalTrip;
            analogTrip        <= next_analogTrip;
            watchEnable       <= next_watchEnable;
            supplyFailIrqFlag <= next_supplyFailIrqFlag;
            readData          <= next_readData;
            irqOut            <= next_irqOut;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Outputs, each straight from a flip-flop.
    // The enum outputs carry the same codes as the register fields.
    assign sfrRdData         = readData;
    assign digitalTripSelect = digitalTrip;
    assign analogTripSelect  = analogTrip;
    assign supplyWatchEnable = watchEnable;
    assign supplyFailIrq     = irqOut;
endmodule

/* File: tb/supply_monitor_properties.sv */
// Checker for the supply monitor: register fields, read path, interrupt gate, recovery hold.
// Assumes it is bound to supply_monitor and sees only that module's ports.
`timescale 1ns/1ns
module supply_monitor_properties
    import supply_monitor_pkg::*;
#(
    parameter int RECOVERY_COUNT = 20,
    parameter int FILTER_COUNT   = 4,
    parameter bit FIVE_VOLT_PART = 1'b0
) (
    input wire logic       clock,
    input wire logic       rstn,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrWrData,
    input wire logic       sfrWrite,
    input wire logic       sfrRead,
    input wire logic [7:0] sfrRdData,
    input wire logic       irqEnablePriorityTwo,
    input wire logic       digitalSupplyCompareRaw,
    input wire logic       analogSupplyCompareRaw,
    input wire trip_code_t digitalTripSelect,
    input wire trip_code_t analogTripSelect,
    input wire logic       supplyWatchEnable,
    input wire logic       supplyFailIrq
);
    logic [3:0]  lowRun;
    logic [3:0]  next_lowRun;
    logic [15:0] goodCount;
    logic [15:0] next_goodCount;
    logic        hit;

    ////////////////////////////////////////////////////////////////////////////
    // A low restarts the good count only once it outlasts the filter span by one cycle, the
    // shortest low that gets through; the masked digital pin of the 5 V part never counts.
    assign hit = sfrAddr == CONTROL_ADDR;
    always_comb begin
        next_lowRun = ((digitalSupplyCompareRaw || FIVE_VOLT_PART) && analogSupplyCompareRaw) ?
                      4'h0 :
                      ((lowRun == 4'hF) ? lowRun : lowRun + 4'h1);
        next_goodCount = (lowRun >= FILTER_COUNT + 1) ? 16'h0000 :
                         ((goodCount == 16'hFFFF) ? goodCount : goodCount + 16'h0001);
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            lowRun    <= 4'h0;
            goodCount <= 16'h0000;
        end else begin
            lowRun    <= next_lowRun;
            goodCount <= next_goodCount;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // One clock domain, so clock and disable are given once.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_irq_gated: assert property (
        !irqEnablePriorityTwo |=> !supplyFailIrq) else $error("irq while disabled");
    a_irq_cause: assert property (
        $rose(supplyFailIrq) |-> $past(irqEnablePriorityTwo)) else $error("irq rose unenabled");
    a_read_idle: assert property (
        !(sfrRead && hit) |=> sfrRdData == 8'h00) else $error("read data not idle");
    a_read_fields: assert property (
        sfrRead && hit |=> sfrRdData[4:0] == {$past(digitalTripSelect),
        $past(analogTripSelect), $past(supplyWatchEnable)}) else $error("read field wrong");
    a_write_fields: assert property (
        sfrWrite && hit |=> {digitalTripSelect, analogTripSelect, supplyWatchEnable}
        == 5'($past(sfrWrData))) else $error("write not taken");
    a_fields_hold: assert property (
        !(sfrWrite && hit) |=> $stable({digitalTripSelect, analogTripSelect,
        supplyWatchEnable})) else $error("fields changed without write");
    a_recovery_hold: assert property (
        $fell(supplyFailIrq) && $past(irqEnablePriorityTwo) && !$past(sfrWrite)
        && !$past(sfrWrite, 2) |-> goodCount >= RECOVERY_COUNT) else $error("early clear");
    a_low_sets: assert property (
        (lowRun == 4'hF && supplyWatchEnable && irqEnablePriorityTwo) ##1
        irqEnablePriorityTwo |=> supplyFailIrq) else $error("low supply not flagged");
endmodule

bind supply_monitor supply_monitor_properties #(
    .RECOVERY_COUNT(RECOVERY_COUNT),
    .FILTER_COUNT  (FILTER_COUNT),
    .FIVE_VOLT_PART(FIVE_VOLT_PART)
) props_u (
    .clock(clock), .rstn(rstn), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData),
    .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrRdData(sfrRdData),
    .irqEnablePriorityTwo(irqEnablePriorityTwo),
    .digitalSupplyCompareRaw(digitalSupplyCompareRaw),
    .analogSupplyCompareRaw(analogSupplyCompareRaw), .digitalTripSelect(digitalTripSelect),
    .analogTripSelect(analogTripSelect), .supplyWatchEnable(supplyWatchEnable),
    .supplyFailIrq(supplyFailIrq)
);

/* File: tb/supply_monitor_tb.sv */
// Self-checking bench for the supply monitor: register accesses and comparator pins.
// Assumes short filter and recovery counts, so the run takes a few hundred cycles.
`timescale 1ns/1ns
module supply_monitor_tb;
    import supply_monitor_pkg::*;
    logic       clock, rstn, sfrWrite, sfrRead, irqEn, dig, ana, watch, irq;
    logic [7:0] sfrAddr, sfrWrData, sfrRdData;
    trip_code_t digTrip, anaTrip;
    logic       fiveIrq;
    logic [7:0] fiveRdData;
    int         num_errors = 0;
    int         n_checks = 0;

    supply_monitor #(.RECOVERY_COUNT(20), .FILTER_COUNT(4)) dut_u (
        .clock(clock), .rstn(rstn), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData),
        .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrRdData(sfrRdData),
        .irqEnablePriorityTwo(irqEn), .digitalSupplyCompareRaw(dig),
        .analogSupplyCompareRaw(ana), .digitalTripSelect(digTrip),
        .analogTripSelect(anaTrip), .supplyWatchEnable(watch), .supplyFailIrq(irq));

    // Second copy as the 5 V part, sharing every input; its digital drops must not flag.
    supply_monitor #(.RECOVERY_COUNT(20), .FILTER_COUNT(4), .FIVE_VOLT_PART(1'b1)) dutFive_u (
        .clock(clock), .rstn(rstn), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData),
        .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrRdData(fiveRdData),
        .irqEnablePriorityTwo(irqEn), .digitalSupplyCompareRaw(dig),
        .analogSupplyCompareRaw(ana), .digitalTripSelect(), .analogTripSelect(),
        .supplyWatchEnable(), .supplyFailIrq(fiveIrq));

    ////////////////////////////////////////////////////////////////////////////
    // Clock of 100 ns; inputs move on the falling edge to stay clear of sampling.
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    // Strobes stand across exactly one rising edge, as the access protocol asks.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        sfrAddr = a;
        sfrWrData = d;
        sfrWrite = 1'b1;
        @(negedge clock);
        sfrWrite = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock);
        sfrAddr = a;
        sfrRead = 1'b1;
        @(negedge clock);
        sfrRead = 1'b0;
        chk(sfrRdData, exp);
    endtask
    task automatic final_report();
        $display("Checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence; waits are sized from the filter count of 4 and recovery of 20.
    initial begin
        rstn = 1'b0;
        sfrAddr = 8'h00;
        sfrWrData = 8'h00;
        sfrWrite = 1'b0;
        sfrRead = 1'b0;
        irqEn = 1'b1;
        dig = 1'b1;
        ana = 1'b1;
        cyc(20);
        rstn = 1'b1;
        rd(8'hDF, 8'hDE);
        chk({3'b000, digTrip, anaTrip, watch}, 8'h1E);
        chk({7'h00, irq}, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(8'hDF, {3'b000, 2'(c), ~2'(c), 1'b1});
            chk({3'b000, digTrip, anaTrip, watch}, {3'b000, 2'(c), ~2'(c), 1'b1});
            rd(8'hDF, {3'b110, 2'(c), ~2'(c), 1'b1});
        end
        wr(8'hDF, 8'h1F);
        dig = 1'b0;
        cyc(20);
        rd(8'hDF, 8'h7F);
        chk(fiveRdData, 8'h5F);
        chk({7'h00, irq}, 8'h01);
        chk({7'h00, fiveIrq}, 8'h00);
        wr(8'hDF, 8'h1F);
        rd(8'hDF, 8'h7F);
        irqEn = 1'b0;
        cyc(2);
        chk({7'h00, irq}, 8'h00);
        irqEn = 1'b1;
        dig = 1'b1;
        cyc(15);
        chk({7'h00, irq}, 8'h01);
        dig = 1'b0;
        cyc(10);
        dig = 1'b1;
        cyc(25);
        chk({7'h00, irq}, 8'h01);
        cyc(20);
        chk({7'h00, irq}, 8'h00);
        ana = 1'b0;
        cyc(2);
        ana = 1'b1;
        cyc(15);
        rd(8'hDF, 8'hDF);
        ana = 1'b0;
        cyc(20);
        rd(8'hDF, 8'hBF);
        ana = 1'b1;
        cyc(50);
        rd(8'hDF, 8'hDF);
        wr(8'hDF, 8'h3F);
        rd(8'hDF, 8'hFF);
        wr(8'hDF, 8'h1F);
        rd(8'hDF, 8'hDF);
        wr(8'hDF, 8'h1E);
        dig = 1'b0;
        cyc(20);
        rd(8'hDF, 8'h5E);
        chk({7'h00, irq}, 8'h00);
        dig = 1'b1;
        cyc(10);
        wr(8'hDE, 8'h21);
        rd(8'hDE, 8'h00);
        rd(8'hDF, 8'hDE);
        final_report();
    end

    // The sequence needs well under 1000 cycles; a hang is cut off at 3000.
    initial begin
        repeat (3000) @(posedge clock);
        num_errors++;
        final_report();
    end
endmodule
